//--- design/uef_defines.svh
// register indices, field positions, reset values and counts
`ifndef UEF_DEFINES_SVH
`define UEF_DEFINES_SVH
`define UEF_IDX_INTF   9'h190
`define UEF_IDX_ERRF   9'h192
`define UEF_IDX_ERRE   9'h193
`define UEF_IDX_STAT   9'h194
`define UEF_IDX_CTRL   9'h195
`define UEF_BIT_BTS    7
`define UEF_BIT_OWN    6
`define UEF_BIT_WRT    5
`define UEF_BIT_BTO    4
`define UEF_BIT_BYTE_MULTIPLE_ERROR_FLAG   3
`define UEF_BIT_DATA_CHECKSUM_ERROR_FLAG  2
`define UEF_BIT_TOKEN_CHECKSUM_ERROR_FLAG   1
`define UEF_BIT_PID    0
`define UEF_BIT_DONE   3
`define UEF_BIT_UERR   1
`define UEF_BIT_SUSP   1
`define UEF_RST_ERRF   8'h00
`define UEF_RST_ERRE   8'h00
`define UEF_RST_SUSP   1'b0
`define UEF_RST_STAT   8'h00
`define UEF_TURN_LIMIT 5'h11
`define UEF_TURN_SAT   5'h12
`define UEF_FIFO_DEPTH 3'h4
`endif

//--- design/uef_pkg.sv
// shared types and helpers for the usb error and status block
`include "uef_defines.svh"
package uef_pkg;
  typedef logic [11:0] uef_addr_type;
  typedef logic [7:0]  uef_byte_type;
  typedef logic [8:0]  uef_index_type;

  function automatic uef_addr_type uef_byte_addr(input uef_index_type idx);
    return {1'b0, idx, 2'b00};
  endfunction

  function automatic logic uef_is_mapped(input uef_index_type idx);
    return (idx == `UEF_IDX_INTF) || (idx == `UEF_IDX_ERRF) ||
           (idx == `UEF_IDX_ERRE) || (idx == `UEF_IDX_STAT) ||
           (idx == `UEF_IDX_CTRL);
  endfunction
endpackage

//--- design/uef_stat_if.sv
// carrier between the main block and its status queue
interface uef_stat_if;
  logic                  push_valid;
  uef_pkg::uef_byte_type push_data;
  logic                  pop;
  logic                  full;
  logic                  empty;
  uef_pkg::uef_byte_type head;
  modport fifo (input push_valid, push_data, pop, output full, empty, head);
  modport user (output push_valid, push_data, pop, input full, empty, head);
endinterface

//--- design/uef_stat_fifo.sv
// four-entry queue of completed-transaction status
`include "uef_defines.svh"
module uef_stat_fifo (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // queue port
  uef_stat_if.fifo st
);
  import uef_pkg::*;

  typedef struct packed {
    logic [3:0][7:0] mem;
    logic [1:0]      wr;
    logic [1:0]      rd;
    logic [2:0]      cnt;
  } uef_fifo_state_type;

  uef_fifo_state_type s_q;
  uef_fifo_state_type s_d;
  logic               push_ok;
  logic               pop_ok;

  always_comb begin
    s_d     = s_q;
    push_ok = st.push_valid && (s_q.cnt != `UEF_FIFO_DEPTH);
    pop_ok  = st.pop && (s_q.cnt != 3'h0);
    if (push_ok) begin
      s_d.mem[s_q.wr] = st.push_data;
      s_d.wr          = s_q.wr + 2'h1;
    end
    if (pop_ok) begin
      s_d.rd = s_q.rd + 2'h1;
    end
    s_d.cnt = s_q.cnt + 3'(push_ok) - 3'(pop_ok);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign st.full  = (s_q.cnt == `UEF_FIFO_DEPTH);
  assign st.empty = (s_q.cnt == 3'h0);
  assign st.head  = s_q.mem[s_q.rd];

  chk_queue_keeps_push: assert property (@(posedge mclk) disable iff (srst)
    st.push_valid && !st.full && !st.pop |=> s_q.cnt == $past(s_q.cnt) + 3'h1)
    else $error("queued status was dropped");
  chk_full_no_overwrite: assert property (@(posedge mclk) disable iff (srst)
    st.full && st.push_valid && !st.pop |=> st.full && st.head == $past(st.head))
    else $error("full queue was overwritten");
  cov_queue_full: cover property (@(posedge mclk) disable iff (srst) st.full);
endmodule

//--- design/uef_top.sv
// usb error flags, error enables and transaction status window
//
// What this block does
// - unowned descriptor on token sets ownership error
// - software write lost to engine write: collision
// - turnaround over 17 bit times flags timeout
// - data field not whole bytes flags error
// - bad token checksum flags error, rejects token
// - one enable per flag at same position
// - finished descriptor use records transaction status
// - queue up to four pending status entries
// - status window valid only while done flag set
// - clearing done flag loads next queued status
// - valid next entry reasserts done flag at once
// - next status kept, never dropped while pending
// - flags set as soon as error is seen
// - enabled flags ORed into summary error bit
// - flags stay set until written zero
//
// Added by the designer: the APB register port.
`include "uef_defines.svh"
module uef_top (
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   srst,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire uef_pkg::uef_addr_type  paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // serial engine error events
  input  wire logic                   bit_stuff_detect,
  input  wire logic                   data_crc_detect,
  input  wire logic                   pid_check_detect,
  input  wire logic                   token_crc_detect,
  input  wire logic                   data_end,
  input  wire logic [2:0]             data_bit_count,
  input  wire logic                   bit_tick,
  input  wire logic                   turnaround_active,
  // serial engine descriptor and register access
  input  wire logic                   token_service,
  input  wire logic                   descriptor_owner_bit,
  input  wire logic                   engine_reg_wr,
  input  wire uef_pkg::uef_index_type engine_reg_idx,
  // transaction completion
  input  wire logic                   txn_done,
  input  wire uef_pkg::uef_byte_type  txn_status,
  output logic                        txn_refuse,
  // results to the engine and interrupt logic
  output logic                        buffer_access_grant,
  output logic                        token_reject,
  output logic                        usb_error_summary,
  output logic                        transaction_done_flag,
  output logic                        suspend_control
);
  import uef_pkg::*;

  typedef struct packed {
    uef_byte_type err;
    uef_byte_type en;
    logic         susp;
    logic         done;
    uef_byte_type window;
    logic [4:0]   turn_cnt;
    logic [31:0]  rdata;
    logic         grant;
    logic         reject;
  } uef_state_type;

  uef_state_type s_q;
  uef_state_type s_d;
  uef_stat_if    stq ();

  uef_index_type idx;
  logic          setup;
  logic          access;
  logic          mapped;
  logic          wr_req;
  logic          collision;
  logic          wr_ok;
  logic          clear_done;
  logic          load_next;
  logic          turn_over;
  uef_byte_type  set_vec;
  uef_byte_type  keep_mask;
  uef_byte_type  rd_byte;

  uef_stat_fifo u_fifo (
    .mclk (mclk),
    .srst (srst),
    .st   (stq.fifo)
  );

  // apb decode
  assign idx    = paddr[10:2];
  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign mapped = (paddr[1:0] == 2'h0) && !paddr[11] && uef_is_mapped(idx);
  assign wr_req = access && pwrite && mapped;

  // engine writing the same register wins the cycle
  assign collision = wr_req && engine_reg_wr && (engine_reg_idx == idx);
  assign wr_ok     = wr_req && !collision;

  assign pready  = access;
  assign pslverr = access && !mapped;
  assign prdata  = s_q.rdata;

  // turnaround limit passed on this bit time
  assign turn_over = turnaround_active && bit_tick &&
                     (s_q.turn_cnt == `UEF_TURN_LIMIT);

  assign clear_done = wr_ok && (idx == `UEF_IDX_INTF) && !pwdata[`UEF_BIT_DONE];
  // next entry goes straight into the window
  assign load_next  = !stq.empty && (!s_q.done || clear_done);

  // queue side
  assign stq.push_valid = txn_done;
  assign stq.push_data  = txn_status;
  assign stq.pop        = load_next;
  assign txn_refuse     = txn_done && stq.full;

  always_comb begin
    set_vec                = '0;
    set_vec[`UEF_BIT_BTS]  = bit_stuff_detect;
    set_vec[`UEF_BIT_OWN]  = token_service && !descriptor_owner_bit;
    set_vec[`UEF_BIT_WRT]  = collision;
    set_vec[`UEF_BIT_BTO]  = turn_over;
    set_vec[`UEF_BIT_BYTE_MULTIPLE_ERROR_FLAG] = data_end && (data_bit_count != 3'h0);
    set_vec[`UEF_BIT_DATA_CHECKSUM_ERROR_FLAG] = data_crc_detect;
    set_vec[`UEF_BIT_TOKEN_CHECKSUM_ERROR_FLAG] = token_crc_detect;
    set_vec[`UEF_BIT_PID]  = pid_check_detect;
  end

  // read mux
  always_comb begin
    rd_byte = 8'h00;
    unique case (idx)
      `UEF_IDX_INTF: begin
        rd_byte[`UEF_BIT_DONE] = s_q.done;
        rd_byte[`UEF_BIT_UERR] = usb_error_summary;
      end
      `UEF_IDX_ERRF: rd_byte = s_q.err;
      `UEF_IDX_ERRE: rd_byte = s_q.en;
      `UEF_IDX_STAT: rd_byte = s_q.done ? s_q.window : 8'h00;
      `UEF_IDX_CTRL: rd_byte[`UEF_BIT_SUSP] = s_q.susp;
      default:       rd_byte = 8'h00;
    endcase
  end

  always_comb begin
    s_d = s_q;
    // write zero clears, blocked in suspend; a new event wins
    keep_mask = 8'hFF;
    if (wr_ok && (idx == `UEF_IDX_ERRF) && !s_q.susp) begin
      keep_mask = pwdata[7:0];
    end
    s_d.err = (s_q.err & keep_mask) | set_vec;
    if (wr_ok && (idx == `UEF_IDX_ERRE)) begin
      s_d.en = pwdata[7:0];
    end
    if (wr_ok && (idx == `UEF_IDX_CTRL)) begin
      s_d.susp = pwdata[`UEF_BIT_SUSP];
    end
    // turnaround counter in bit times
    if (!turnaround_active) begin
      s_d.turn_cnt = 5'h00;
    end else if (bit_tick && (s_q.turn_cnt != `UEF_TURN_SAT)) begin
      s_d.turn_cnt = s_q.turn_cnt + 5'h01;
    end
    // done flag and status window
    if (load_next) begin
      s_d.window = stq.head;
      s_d.done   = 1'b1;
    end else if (clear_done) begin
      s_d.done = 1'b0;
    end
    // read data latched in the setup cycle
    if (setup) begin
      s_d.rdata = {24'h000000, rd_byte};
    end
    s_d.grant  = token_service && descriptor_owner_bit;
    s_d.reject = token_crc_detect;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      s_q.err      <= `UEF_RST_ERRF;
      s_q.en       <= `UEF_RST_ERRE;
      s_q.susp     <= `UEF_RST_SUSP;
      s_q.done     <= 1'b0;
      s_q.window   <= `UEF_RST_STAT;
      s_q.turn_cnt <= 5'h00;
      s_q.rdata    <= 32'h00000000;
      s_q.grant    <= 1'b0;
      s_q.reject   <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign usb_error_summary     = |(s_q.err & s_q.en);
  assign transaction_done_flag = s_q.done;
  assign suspend_control       = s_q.susp;
  assign buffer_access_grant   = s_q.grant;
  assign token_reject          = s_q.reject;

  // checks
  chk_owner_error_set: assert property (@(posedge mclk) disable iff (srst)
    token_service && !descriptor_owner_bit |=>
      s_q.err[`UEF_BIT_OWN] && !buffer_access_grant)
    else $error("ownership error not flagged or buffer granted");

  chk_collision_drop: assert property (@(posedge mclk) disable iff (srst)
    collision && (idx == `UEF_IDX_ERRE) |=>
      s_q.err[`UEF_BIT_WRT] && s_q.en == $past(s_q.en))
    else $error("colliding write took effect or was not flagged");

  chk_turn_timeout: assert property (@(posedge mclk) disable iff (srst)
    turnaround_active && bit_tick && s_q.turn_cnt == 5'h10 ##1
      turnaround_active && !bit_tick ##1
      turnaround_active && bit_tick |=> s_q.err[`UEF_BIT_BTO])
    else $error("turnaround timeout missed after 18 bit times");

  chk_token_reject: assert property (@(posedge mclk) disable iff (srst)
    token_crc_detect |=> token_reject && s_q.err[`UEF_BIT_TOKEN_CHECKSUM_ERROR_FLAG])
    else $error("bad token not rejected");

  chk_suspend_lock: assert property (@(posedge mclk) disable iff (srst)
    s_q.susp && wr_ok && idx == `UEF_IDX_ERRF |=> s_q.err == $past(s_q.err | set_vec))
    else $error("error flags changed by write during suspend");

  chk_flag_sticky: assert property (@(posedge mclk) disable iff (srst)
    s_q.err[`UEF_BIT_PID] && !(wr_ok && idx == `UEF_IDX_ERRF) |=> s_q.err[`UEF_BIT_PID])
    else $error("error flag cleared without a write");

  chk_summary_or: assert property (@(posedge mclk) disable iff (srst)
    (set_vec & s_q.en) != 8'h00 |=> usb_error_summary)
    else $error("enabled error did not reach summary");

  chk_done_reload: assert property (@(posedge mclk) disable iff (srst)
    clear_done && !stq.empty |=> transaction_done_flag && s_q.window == $past(stq.head))
    else $error("done flag not reasserted with next entry");

  chk_window_gate: assert property (@(posedge mclk) disable iff (srst)
    setup && !s_q.done && idx == `UEF_IDX_STAT |=> prdata == 32'h00000000)
    else $error("status window read valid without done flag");

  chk_refuse_full: assert property (@(posedge mclk) disable iff (srst)
    txn_done && stq.full |-> txn_refuse)
    else $error("full queue did not refuse transaction");

  cov_reload: cover property (@(posedge mclk) disable iff (srst)
    clear_done && !stq.empty);
  cov_timeout: cover property (@(posedge mclk) disable iff (srst) turn_over);
  cov_collision: cover property (@(posedge mclk) disable iff (srst) collision);
  cov_refuse: cover property (@(posedge mclk) disable iff (srst) txn_refuse);
endmodule

//--- tb/uef_engine_model.sv
// serial engine stand-in: error events, turnaround ticks, completions
module uef_engine_model (
  // clock
  input  wire logic              mclk,
  // engine events
  output logic                   bit_stuff_detect,
  output logic                   data_crc_detect,
  output logic                   pid_check_detect,
  output logic                   token_crc_detect,
  output logic                   data_end,
  output logic [2:0]             data_bit_count,
  output logic                   bit_tick,
  output logic                   turnaround_active,
  // descriptor and register access
  output logic                   token_service,
  output logic                   descriptor_owner_bit,
  output logic                   engine_reg_wr,
  output uef_pkg::uef_index_type engine_reg_idx,
  // completions
  output logic                   txn_done,
  output uef_pkg::uef_byte_type  txn_status,
  input  wire logic              txn_refuse
);
  timeunit 1ns;
  timeprecision 1ns;
  import uef_pkg::*;
  initial begin
    {bit_stuff_detect, data_crc_detect, pid_check_detect, token_crc_detect} = 4'h0;
    {data_end, bit_tick, turnaround_active, token_service} = 4'h0;
    {engine_reg_wr, txn_done} = 2'h0;
    data_bit_count = 3'h2;
    descriptor_owner_bit = 1'b1;
    engine_reg_idx = 9'h1FF;
    txn_status = 8'hA5;
  end
  // one-cycle event by flag position; 4 is a whole-byte data end, 8 a clean token
  task automatic err(input int b);
    @(posedge mclk);
    case (b)
      7: bit_stuff_detect <= 1'b1;
      2: data_crc_detect <= 1'b1;
      0: pid_check_detect <= 1'b1;
      1: token_crc_detect <= 1'b1;
      3, 4: data_end <= 1'b1;
      default: token_service <= 1'b1;
    endcase
    data_bit_count <= (b == 3) ? 3'h5 : 3'h0;
    descriptor_owner_bit <= (b != 6);
    @(posedge mclk);
    {bit_stuff_detect, data_crc_detect, pid_check_detect, token_crc_detect} <= 4'h0;
    {data_end, token_service} <= 2'h0;
    data_bit_count <= 3'h2;
    descriptor_owner_bit <= ~descriptor_owner_bit;
  endtask
  // open turnaround window and give n bit times
  task automatic turn(input int n);
    @(posedge mclk);
    turnaround_active <= 1'b1;
    repeat (n) begin
      @(posedge mclk);
      bit_tick <= 1'b1;
      @(posedge mclk);
      bit_tick <= 1'b0;
    end
    @(posedge mclk);
    turnaround_active <= 1'b0;
  endtask
  // engine register write in the second cycle from now
  task automatic engwr(input uef_index_type idx);
    repeat (2) @(posedge mclk);
    engine_reg_wr <= 1'b1;
    engine_reg_idx <= idx;
    @(posedge mclk);
    engine_reg_wr <= 1'b0;
    engine_reg_idx <= ~idx;
  endtask
  // completed transaction; refusal sampled inside the pulse
  task automatic txn(input uef_byte_type s, output logic r);
    @(posedge mclk);
    txn_done <= 1'b1;
    txn_status <= s;
    @(posedge mclk);
    r = txn_refuse;
    txn_done <= 1'b0;
    txn_status <= ~s;
  endtask
endmodule

//--- tb/usb_error_flags_status_fifo_tb.sv
// bench for the usb error flags and transaction status queue
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module usb_error_flags_status_fifo_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import uef_pkg::*;
  logic          mclk, srst, psel, penable, pwrite, pready, pslverr, er, r;
  uef_addr_type  paddr;
  logic [31:0]   pwdata, prdata, rdv, lf;
  logic          bit_stuff_detect, data_crc_detect, pid_check_detect, token_crc_detect;
  logic          data_end, bit_tick, turnaround_active, token_service;
  logic          descriptor_owner_bit, engine_reg_wr, txn_done, txn_refuse;
  logic          buffer_access_grant, token_reject, usb_error_summary;
  logic          transaction_done_flag, suspend_control;
  logic [2:0]    data_bit_count;
  uef_index_type engine_reg_idx;
  uef_byte_type  txn_status;
  int            err_count, compares, cyc, ef, ee;
  int            q[$];
  int            bits[6] = '{7, 2, 0, 1, 3, 6};
  uef_top dut (.mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .bit_stuff_detect, .data_crc_detect, .pid_check_detect, .token_crc_detect,
    .data_end, .data_bit_count, .bit_tick, .turnaround_active, .token_service,
    .descriptor_owner_bit, .engine_reg_wr, .engine_reg_idx, .txn_done, .txn_status,
    .txn_refuse, .buffer_access_grant, .token_reject, .usb_error_summary,
    .transaction_done_flag, .suspend_control);
  uef_engine_model eng (.mclk, .bit_stuff_detect, .data_crc_detect, .pid_check_detect,
    .token_crc_detect, .data_end, .data_bit_count, .bit_tick, .turnaround_active,
    .token_service, .descriptor_owner_bit, .engine_reg_wr, .engine_reg_idx, .txn_done,
    .txn_status, .txn_refuse);
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // apb transfer: setup, then access held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic e);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chkrd(input string n, input logic [11:0] a, input int e);
    apb(1'b0, a, 32'h0, rdv, er);
    `CHK(n, e[31:0], rdv)
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end
  initial begin
    {srst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 12'h0, 32'h0};
    {err_count, compares, cyc, ef, ee} = '0;
    lf = 32'h0E27;
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    chkrd("flags", 12'h648, 0);
    chkrd("enables", 12'h64C, 0);
    chkrd("window", 12'h650, 0);
    apb(1'b0, 12'h658, 32'h0, rdv, er);
    `CHK("pslverr", 1'b1, er)
    $display("test reset done");
    foreach (bits[i]) begin
      eng.err(bits[i]);
      ef |= 1 << bits[i];
      chkrd("flags", 12'h648, ef);
    end
    eng.err(4);
    chkrd("flags", 12'h648, ef);
    fork
      eng.err(1);
      begin
        repeat (2) @(posedge mclk);
        #1 `CHK("reject", 1'b1, token_reject)
      end
    join
    fork
      eng.err(8);
      begin
        repeat (2) @(posedge mclk);
        #1 `CHK("grant", 1'b1, buffer_access_grant)
      end
    join
    eng.turn(17);
    chkrd("flags", 12'h648, ef);
    eng.turn(18);
    ef |= 16;
    chkrd("flags", 12'h648, ef);
    fork apb(1'b1, 12'h64C, 32'hFF, rdv, er); eng.engwr(9'h193); join
    ef |= 32;
    chkrd("flags", 12'h648, ef);
    chkrd("enables", 12'h64C, 0);
    $display("test error events done");
    apb(1'b1, 12'h654, 32'h2, rdv, er);
    apb(1'b1, 12'h648, 32'h0, rdv, er);
    chkrd("flags", 12'h648, ef);
    `CHK("suspend", 1'b1, suspend_control)
    apb(1'b1, 12'h654, 32'h0, rdv, er);
    repeat (6) begin
      lf = lfsr(lf);
      ee = lf[7:0];
      apb(1'b1, 12'h64C, lf, rdv, er);
      lf = lfsr(lf);
      apb(1'b1, 12'h648, lf | 32'hC0, rdv, er);
      ef &= lf[7:0] | 8'hC0;
      chkrd("flags", 12'h648, ef);
      chkrd("enables", 12'h64C, ee);
      `CHK("summary", |(ef[7:0] & ee[7:0]), usb_error_summary)
    end
    ee = 1;
    apb(1'b1, 12'h64C, 32'h1, rdv, er);
    fork
      apb(1'b1, 12'h648, 32'h0, rdv, er);
      begin
        @(posedge mclk);
        eng.err(0);
      end
    join
    ef = 1;
    chkrd("flags", 12'h648, ef);
    `CHK("summary", 1'b1, usb_error_summary)
    $display("test enables done");
    for (int i = 0; i < 6; i++) begin
      lf = lfsr(lf);
      eng.txn(lf[7:0], r);
      `CHK("refuse", q.size() == 5, r)
      if (q.size() < 5) q.push_back(lf[7:0]);
    end
    repeat (3) @(posedge mclk);
    while (q.size() > 0) begin
      chkrd("window", 12'h650, q[0]);
      apb(1'b1, 12'h640, 32'h0, rdv, er);
      void'(q.pop_front());
      @(posedge mclk);
      #1 `CHK("done", q.size() > 0, transaction_done_flag)
    end
    chkrd("window", 12'h650, 0);
    $display("test status queue done");
    test_done();
  end
endmodule
